// ===== inc/byte_dp_pkg.sv
package byte_dp_pkg;

	// Widths
	localparam int WORD_W  = 24;
	localparam int ADDR_W  = 18;
	localparam int BUS_W   = 32;
	localparam int J_OFS_W = 16;

	// Register byte addresses
	localparam logic [7:0] ADR_ACC    = 8'h00;
	localparam logic [7:0] ADR_REG_I  = 8'h04;
	localparam logic [7:0] ADR_REG_J  = 8'h08;
	localparam logic [7:0] ADR_REG_K  = 8'h0C;
	localparam logic [7:0] ADR_REG_E  = 8'h10;
	localparam logic [7:0] ADR_REG_T  = 8'h14;
	localparam logic [7:0] ADR_EMA    = 8'h18;
	localparam logic [7:0] ADR_CMD    = 8'h1C;
	localparam logic [7:0] ADR_STATUS = 8'h20;

	// Command word fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_OPND_LSB = 8;
	localparam int CMD_XSEL_LSB = 16;

	// Status word fields
	localparam int ST_CC_LSB   = 0;
	localparam int ST_OVF_BIT  = 3;
	localparam int ST_BUSY_BIT = 4;
	localparam int ST_NOP_BIT  = 5;

	// Condition register bits
	localparam int CC_POS  = 0;
	localparam int CC_ZERO = 1;
	localparam int CC_NEG  = 2;

	// Byte selector in index bits 22-23
	localparam int         SEL_LSB  = 22;
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_HI   = 2'h1;
	localparam logic [1:0] SEL_MID  = 2'h2;
	localparam logic [1:0] SEL_LO   = 2'h3;
	localparam int         HI_LSB   = 16;
	localparam int         MID_LSB  = 8;

	// Final-address index register select
	localparam logic [1:0] XSEL_NONE = 2'h0;
	localparam logic [1:0] XSEL_I    = 2'h1;
	localparam logic [1:0] XSEL_J    = 2'h2;
	localparam logic [1:0] XSEL_K    = 2'h3;

	// Register selectors of the register-to-byte copy
	localparam logic [7:0] RSEL_I = 8'h01;
	localparam logic [7:0] RSEL_J = 8'h02;
	localparam logic [7:0] RSEL_K = 8'h04;
	localparam logic [7:0] RSEL_E = 8'h08;
	localparam logic [7:0] RSEL_T = 8'h20;

	localparam logic [7:0] BYTE_MIN = 8'h80;

	typedef enum logic [4:0] {
		op_none                      = 5'h00,
		sign_extend_low_byte         = 5'h01,
		zero_extend_low_byte         = 5'h02,
		logical_compare_operand_byte = 5'h03,
		negate_low_byte              = 5'h04,
		or_operand_into_byte         = 5'h05,
		absolute_low_byte            = 5'h06,
		query_byte_bits              = 5'h07,
		subtract_operand_from_low_byte = 5'h08,
		xor_operand_into_byte        = 5'h09,
		load_operand_to_low_byte     = 5'h0A,
		copy_register_to_low_byte    = 5'h0B,
		load_memory_to_low_byte      = 5'h0C,
		extract_memory_byte          = 5'h0D,
		replace_memory_byte          = 5'h0E,
		store_low_byte_to_memory     = 5'h0F
	} op_t;

	typedef enum logic [1:0] {
		st_idle  = 2'h0,
		st_exec  = 2'h1,
		st_read  = 2'h2,
		st_write = 2'h3
	} state_t;

endpackage : byte_dp_pkg

// ===== logic/byte_alu.sv
`timescale 1ns/1ps

module byte_alu
	import byte_dp_pkg::*;
(
	input  wire op_t          op_i,
	input  wire logic [23:0]  acc_i,
	input  wire logic [7:0]   opnd_i,
	input  wire logic [7:0]   src_i,
	output logic      [23:0]  acc_o,
	output logic              cc_en_o,
	output logic      [2:0]   cc_o,
	output logic              ovf_o
);

	// Byte operation on the accumulator low byte
	always_comb
	begin
		logic [7:0] b;
		logic [7:0] r;
		logic       wr;
		b       = acc_i[7:0];
		r       = b;
		wr      = 1'b0;
		acc_o   = acc_i;
		cc_en_o = 1'b0;
		ovf_o   = 1'b0;
		case (op_i)
			sign_extend_low_byte:
			begin
				acc_o   = {{16{b[7]}}, b};
				cc_en_o = 1'b1;
			end
			zero_extend_low_byte: acc_o = {16'h0000, b};
			negate_low_byte:
			begin
				r       = 8'(~b + 8'h01);
				ovf_o   = (b == BYTE_MIN);
				wr      = 1'b1;
				cc_en_o = 1'b1;
			end
			or_operand_into_byte:
			begin
				r       = b | opnd_i;
				wr      = 1'b1;
				cc_en_o = 1'b1;
			end
			absolute_low_byte:
			begin
				r       = b[7] ? 8'(~b + 8'h01) : b;
				ovf_o   = (b == BYTE_MIN);
				wr      = 1'b1;
				cc_en_o = 1'b1;
			end
			query_byte_bits:
			begin
				r       = b & opnd_i;
				cc_en_o = 1'b1;
			end
			subtract_operand_from_low_byte:
			begin
				r       = 8'(b - opnd_i);
				ovf_o   = (b[7] != opnd_i[7]) && (r[7] != b[7]);
				wr      = 1'b1;
				cc_en_o = 1'b1;
			end
			xor_operand_into_byte:
			begin
				r       = b ^ opnd_i;
				wr      = 1'b1;
				cc_en_o = 1'b1;
			end
			load_operand_to_low_byte:
			begin
				r  = opnd_i;
				wr = 1'b1;
			end
			copy_register_to_low_byte:
			begin
				r  = src_i;
				wr = 1'b1;
			end
			load_memory_to_low_byte, extract_memory_byte:
			begin
				r       = src_i;
				wr      = 1'b1;
				cc_en_o = 1'b1;
			end
			default: r = b;
		endcase
		if (wr)
			acc_o = {acc_i[23:8], r};
		// Negative from bit 7, zero from all eight bits
		cc_o          = 3'h0;
		cc_o[CC_NEG]  = r[7];
		cc_o[CC_ZERO] = (r == 8'h00);
		cc_o[CC_POS]  = !r[7] && (r != 8'h00);
		if (op_i == logical_compare_operand_byte)
		begin
			// Unsigned compare, accumulator untouched
			cc_en_o       = 1'b1;
			cc_o[CC_NEG]  = b < opnd_i;
			cc_o[CC_ZERO] = b == opnd_i;
			cc_o[CC_POS]  = b > opnd_i;
		end
	end

endmodule : byte_alu

// ===== logic/byte_datapath.sv
`timescale 1ns/1ps


module byte_datapath
	import byte_dp_pkg::*;
(
	input  wire  logic               clk_i,
	input  wire  logic               rst_i,
	input  wire  logic               wb_cyc_i,
	input  wire  logic               wb_stb_i,
	input  wire  logic               wb_we_i,
	input  wire  logic [7:0]         wb_adr_i,
	input  wire  logic [3:0]         wb_sel_i,
	input  wire  logic [BUS_W-1:0]   wb_dat_i,
	output logic       [BUS_W-1:0]   wb_dat_o,
	output logic                     wb_ack_o,
	output logic       [ADDR_W-1:0]  mem_adr_o,
	output logic                     mem_stb_o,
	output logic                     mem_we_o,
	output logic       [WORD_W-1:0]  mem_dat_o,
	input  wire  logic [WORD_W-1:0]  mem_dat_i,
	input  wire  logic               mem_ack_i
);

	typedef struct packed {
		state_t              st;
		op_t                 op;
		logic [7:0]          opnd;
		logic [1:0]          xsel;
		logic [WORD_W-1:0]   acc;
		logic [WORD_W-1:0]   ri;
		logic [WORD_W-1:0]   rj;
		logic [WORD_W-1:0]   rk;
		logic [WORD_W-1:0]   re;
		logic [WORD_W-1:0]   rt;
		logic [ADDR_W-1:0]   effective_memory_address;
		logic [2:0]          cc;
		logic                ovf;
		logic                nop;
		logic                ack;
		logic [BUS_W-1:0]    rdat;
		logic [ADDR_W-1:0]   madr;
		logic                mstb;
		logic                mwe;
		logic [WORD_W-1:0]   mdat;
	} dp_state_t;

	dp_state_t s_q;
	dp_state_t s_d;

	logic [WORD_W-1:0] alu_acc;
	logic              alu_cc_en;
	logic [2:0]        alu_cc;
	logic              alu_ovf;
	logic [7:0]        alu_src;
	logic [WORD_W-1:0] xreg;
	logic [WORD_W-1:0] ext_base;
	logic [WORD_W-1:0] rep_base;
	logic [ADDR_W-1:0] ext_adr;
	logic [ADDR_W-1:0] rep_adr;
	logic [7:0]        ext_byte;
	logic [WORD_W-1:0] rep_word;
	logic              req;
	logic              busy;

	////////////////////////////////////////////////////////////////////////////
	// Address forming and byte selection

	// Index register named by the final-address indexing
	always_comb
	begin
		case (s_q.xsel)
			XSEL_I:  xreg = s_q.ri;
			XSEL_J:  xreg = s_q.rj;
			XSEL_K:  xreg = s_q.rk;
			default: xreg = '0;
		endcase
	end

	// Implied index, ORed with the named one
	assign ext_base = s_q.rj | xreg;
	assign rep_base = s_q.ri | xreg;
	assign ext_adr  = ADDR_W'(s_q.effective_memory_address + ADDR_W'(ext_base[J_OFS_W-1:0]));
	assign rep_adr  = ADDR_W'(s_q.effective_memory_address + rep_base[ADDR_W-1:0]);

	// Byte pulled out of the fetched word
	always_comb
	begin
		case (s_q.rj[SEL_LSB +: 2])
			SEL_HI:  ext_byte = mem_dat_i[HI_LSB +: 8];
			SEL_MID: ext_byte = mem_dat_i[MID_LSB +: 8];
			default: ext_byte = mem_dat_i[7:0];
		endcase
	end

	// Word with the low byte merged into the chosen lane
	always_comb
	begin
		rep_word = mem_dat_i;
		if (s_q.op == store_low_byte_to_memory)
			rep_word[7:0] = s_q.acc[7:0];
		else
		begin
			case (s_q.ri[SEL_LSB +: 2])
				SEL_HI:  rep_word[HI_LSB +: 8]  = s_q.acc[7:0];
				SEL_MID: rep_word[MID_LSB +: 8] = s_q.acc[7:0];
				SEL_LO:  rep_word[7:0]          = s_q.acc[7:0];
				default: rep_word = mem_dat_i;
			endcase
		end
	end

	// Source byte for copies and memory loads
	always_comb
	begin
		alu_src = 8'h00;
		if (s_q.st == st_read)
			alu_src = (s_q.op == extract_memory_byte) ? ext_byte : mem_dat_i[7:0];
		else if (s_q.opnd == RSEL_I)
			alu_src = s_q.ri[7:0];
		else if (s_q.opnd == RSEL_J)
			alu_src = s_q.rj[7:0];
		else if (s_q.opnd == RSEL_K)
			alu_src = s_q.rk[7:0];
		else if (s_q.opnd == RSEL_E)
			alu_src = s_q.re[7:0];
		else if (s_q.opnd == RSEL_T)
			alu_src = s_q.rt[7:0];
	end

	byte_alu u_alu (
		.op_i    (s_q.op),
		.acc_i   (s_q.acc),
		.opnd_i  (s_q.opnd),
		.src_i   (alu_src),
		.acc_o   (alu_acc),
		.cc_en_o (alu_cc_en),
		.cc_o    (alu_cc),
		.ovf_o   (alu_ovf)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register bus and sequencing

	// Byte-lane merge of a bus write
	function automatic logic [BUS_W-1:0] lane_merge(input logic [BUS_W-1:0] old,
	                                                input logic [BUS_W-1:0] dat,
	                                                input logic [3:0]       sel);
		logic [BUS_W-1:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (dat & m);
	endfunction : lane_merge

	assign req  = wb_cyc_i && wb_stb_i && !s_q.ack;
	assign busy = (s_q.st != st_idle);

	// Next state
	always_comb
	begin
		logic [7:0]       a;
		logic [BUS_W-1:0] st_word;
		s_d     = s_q;
		a       = {wb_adr_i[7:2], 2'b00};
		st_word = '0;
		st_word[ST_CC_LSB +: 3] = s_q.cc;
		st_word[ST_OVF_BIT]     = s_q.ovf;
		st_word[ST_BUSY_BIT]    = busy;
		st_word[ST_NOP_BIT]     = s_q.nop;
		s_d.ack = req;
		// Reads, unmapped answers zero
		if (req && !wb_we_i)
		begin
			if (a == ADR_ACC)
				s_d.rdat = BUS_W'(s_q.acc);
			else if (a == ADR_REG_I)
				s_d.rdat = BUS_W'(s_q.ri);
			else if (a == ADR_REG_J)
				s_d.rdat = BUS_W'(s_q.rj);
			else if (a == ADR_REG_K)
				s_d.rdat = BUS_W'(s_q.rk);
			else if (a == ADR_REG_E)
				s_d.rdat = BUS_W'(s_q.re);
			else if (a == ADR_REG_T)
				s_d.rdat = BUS_W'(s_q.rt);
			else if (a == ADR_EMA)
				s_d.rdat = BUS_W'(s_q.effective_memory_address);
			else if (a == ADR_CMD)
				s_d.rdat = BUS_W'({s_q.xsel, s_q.opnd, 3'h0, s_q.op});
			else if (a == ADR_STATUS)
				s_d.rdat = st_word;
			else
				s_d.rdat = '0;
		end
		// Writes, data registers locked while busy
		if (req && wb_we_i)
		begin
			if (a == ADR_STATUS && wb_sel_i[0] && wb_dat_i[ST_OVF_BIT])
				s_d.ovf = 1'b0;
			else if (!busy)
			begin
				if (a == ADR_ACC)
					s_d.acc = WORD_W'(lane_merge(BUS_W'(s_q.acc), wb_dat_i, wb_sel_i));
				else if (a == ADR_REG_I)
					s_d.ri = WORD_W'(lane_merge(BUS_W'(s_q.ri), wb_dat_i, wb_sel_i));
				else if (a == ADR_REG_J)
					s_d.rj = WORD_W'(lane_merge(BUS_W'(s_q.rj), wb_dat_i, wb_sel_i));
				else if (a == ADR_REG_K)
					s_d.rk = WORD_W'(lane_merge(BUS_W'(s_q.rk), wb_dat_i, wb_sel_i));
				else if (a == ADR_REG_E)
					s_d.re = WORD_W'(lane_merge(BUS_W'(s_q.re), wb_dat_i, wb_sel_i));
				else if (a == ADR_REG_T)
					s_d.rt = WORD_W'(lane_merge(BUS_W'(s_q.rt), wb_dat_i, wb_sel_i));
				else if (a == ADR_EMA)
					s_d.effective_memory_address = ADDR_W'(lane_merge(BUS_W'(s_q.effective_memory_address), wb_dat_i, wb_sel_i));
				else if (a == ADR_CMD)
				begin
					// Command start, byte enables ignored
					s_d.op   = op_t'(wb_dat_i[CMD_OP_LSB +: 5]);
					s_d.opnd = wb_dat_i[CMD_OPND_LSB +: 8];
					s_d.xsel = wb_dat_i[CMD_XSEL_LSB +: 2];
					s_d.nop  = 1'b0;
					s_d.st   = st_exec;
				end
			end
		end
		// Operation sequencer
		case (s_q.st)
			st_exec:
			begin
				s_d.st = st_idle;
				if (s_q.op == extract_memory_byte)
				begin
					s_d.madr = ext_adr;
					s_d.mstb = 1'b1;
					s_d.mwe  = 1'b0;
					s_d.st   = st_read;
				end
				else if (s_q.op == replace_memory_byte)
				begin
					if (s_q.ri[SEL_LSB +: 2] == SEL_NONE)
						s_d.nop = 1'b1;
					else
					begin
						s_d.madr = rep_adr;
						s_d.mstb = 1'b1;
						s_d.mwe  = 1'b0;
						s_d.st   = st_read;
					end
				end
				else if (s_q.op == store_low_byte_to_memory || s_q.op == load_memory_to_low_byte)
				begin
					s_d.madr = s_q.effective_memory_address;
					s_d.mstb = 1'b1;
					s_d.mwe  = 1'b0;
					s_d.st   = st_read;
				end
				else
				begin
					s_d.acc = alu_acc;
					if (alu_cc_en)
						s_d.cc = alu_cc;
					if (alu_ovf)
						s_d.ovf = 1'b1;
				end
			end
			st_read:
			begin
				if (mem_ack_i)
				begin
					s_d.mstb = 1'b0;
					if (s_q.op == replace_memory_byte || s_q.op == store_low_byte_to_memory)
					begin
						s_d.mdat = rep_word;
						s_d.st   = st_write;
					end
					else
					begin
						s_d.acc = alu_acc;
						s_d.cc  = alu_cc;
						s_d.st  = st_idle;
					end
				end
			end
			st_write:
			begin
				if (!s_q.mstb)
				begin
					s_d.mstb = 1'b1;
					s_d.mwe  = 1'b1;
				end
				else if (mem_ack_i)
				begin
					s_d.mstb = 1'b0;
					s_d.mwe  = 1'b0;
					s_d.st   = st_idle;
				end
			end
			default: ;
		endcase
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_q    <= '0;
			s_q.st <= st_idle;
			s_q.op <= op_none;
		end
		else
			s_q <= s_d;
	end

	assign wb_dat_o  = s_q.rdat;
	assign wb_ack_o  = s_q.ack;
	assign mem_adr_o = s_q.madr;
	assign mem_stb_o = s_q.mstb;
	assign mem_we_o  = s_q.mwe;
	assign mem_dat_o = s_q.mdat;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence read_done(op_t o);
		s_q.st == st_read && s_q.op == o && mem_ack_i;
	endsequence

	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held over two cycles");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	a_neg_overflow: assert property (s_q.st == st_exec && s_q.op == negate_low_byte
		&& s_q.acc[7:0] == BYTE_MIN |=> s_q.ovf && s_q.acc[7:0] == BYTE_MIN)
		else $error("negate of 0x80 gave no overflow");
	a_neg_value: assert property (s_q.st == st_exec && s_q.op == negate_low_byte
		|=> s_q.acc[23:8] == $past(s_q.acc[23:8]) && 8'(s_q.acc[7:0] + $past(s_q.acc[7:0])) == 8'h00)
		else $error("negate result wrong");
	a_sext_fill: assert property (s_q.st == st_exec && s_q.op == sign_extend_low_byte
		|=> s_q.acc[23:8] == {16{s_q.acc[7]}} && s_q.cc[CC_NEG] == s_q.acc[7])
		else $error("sign extension wrong");
	a_zext_clear: assert property (s_q.st == st_exec && s_q.op == zero_extend_low_byte
		|=> s_q.acc[23:8] == 16'h0000 && $stable(s_q.cc) && $stable(s_q.acc[7:0]))
		else $error("zero extension wrong");
	a_cmp_keeps: assert property (s_q.st == st_exec && (s_q.op == logical_compare_operand_byte ||
		s_q.op == query_byte_bits) |=> $stable(s_q.acc))
		else $error("compare or query changed accumulator");
	a_query_zero: assert property (s_q.st == st_exec && s_q.op == query_byte_bits
		&& (s_q.acc[7:0] & s_q.opnd) == 8'h00 |=> s_q.cc[CC_ZERO] && !s_q.cc[CC_NEG])
		else $error("query zero condition wrong");
	a_replace_nop: assert property (s_q.st == st_exec && s_q.op == replace_memory_byte
		&& s_q.ri[SEL_LSB +: 2] == SEL_NONE |=> !mem_stb_o && s_q.st == st_idle && s_q.nop)
		else $error("replace with selector 00 touched memory");
	a_extract_adr: assert property (s_q.st == st_exec && s_q.op == extract_memory_byte
		|=> mem_adr_o == ADDR_W'(s_q.effective_memory_address + ADDR_W'(s_q.rj[J_OFS_W-1:0]
		| (s_q.xsel == XSEL_K ? s_q.rk[J_OFS_W-1:0] : s_q.xsel == XSEL_I ? s_q.ri[J_OFS_W-1:0] : '0)))
		&& mem_stb_o && !mem_we_o)
		else $error("extract address wrong");
	a_store_merge: assert property (read_done(store_low_byte_to_memory)
		|=> ##1 mem_we_o && mem_dat_o[23:8] == $past(mem_dat_i[23:8], 2)
		&& mem_dat_o[7:0] == s_q.acc[7:0])
		else $error("store did not keep upper memory bits");
	a_extract_hi: assert property (read_done(extract_memory_byte) ##0 s_q.rj[SEL_LSB +: 2] == SEL_HI
		|=> s_q.acc[7:0] == $past(mem_dat_i[HI_LSB +: 8]))
		else $error("extract of high byte wrong");

endmodule : byte_datapath

// ===== sim/mem_model.sv
`timescale 1ns/1ps

// Word memory on the far side of the memory port
module mem_model
	import byte_dp_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              slow_i,
	input  wire logic [ADDR_W-1:0] adr_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [WORD_W-1:0] dat_i,
	output logic      [WORD_W-1:0] dat_o,
	output logic                   ack_o
);
	logic [WORD_W-1:0] words [256];
	logic [WORD_W-1:0] rd_q;
	logic [1:0]        wait_q;

	// One ack pulse per request, promptly or after three idle cycles
	always @(posedge clk_i)
	begin
		ack_o <= 1'b0;
		if (rst_i)
		begin
			wait_q <= 2'h0;
			rd_q   <= '0;
		end
		else if (stb_i && !ack_o)
		begin
			if (wait_q == (slow_i ? 2'h3 : 2'h0))
			begin
				ack_o  <= 1'b1;
				wait_q <= 2'h0;
				if (we_i)
					words[adr_i[7:0]] <= dat_i;
				else
					rd_q <= words[adr_i[7:0]];
			end
			else
				wait_q <= wait_q + 2'h1;
		end
	end

	// Read word valid only with ack, inverted otherwise
	assign dat_o = ack_o ? rd_q : ~rd_q;
endmodule : mem_model

// ===== sim/byte_processing_datapath_bench.sv
`timescale 1ns/1ps

module byte_processing_datapath_bench;
	import byte_dp_pkg::*;
	logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow;
	logic [7:0]        wb_adr_i;
	logic [3:0]        wb_sel_i;
	logic [31:0]       wb_dat_i, wb_dat_o, d;
	logic [ADDR_W-1:0] mem_adr_o;
	logic              mem_stb_o, mem_we_o, mem_ack_i;
	logic [WORD_W-1:0] mem_dat_o, mem_dat_i;
	int                fails, n_tests;

	byte_datapath dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .mem_adr_o, .mem_stb_o, .mem_we_o, .mem_dat_o, .mem_dat_i, .mem_ack_i);
	mem_model mem (.clk_i, .rst_i, .slow_i(slow), .adr_i(mem_adr_o), .stb_i(mem_stb_o), .we_i(mem_we_o),
		.dat_i(mem_dat_o), .dat_o(mem_dat_i), .ack_o(mem_ack_i));

	////////////////////////////////////////////////////////////////
	// Compare, verdict and bus tasks
	task check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want)
		begin
			fails++;
			$display("[FAIL] %0t: got %h expected %h", $time, seen, want);
		end
	endtask : check

	task complete_run;
		$display("Checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	// Classic single cycle, held until ack is sampled
	task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rdat);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		if (n == 20)
			check({31'h0, wb_ack_o}, 32'h1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask : wb

	task wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] x;
		wb(1'b1, adr, dat, x);
	endtask : wr

	task rd(input logic [7:0] adr, output logic [31:0] x);
		wb(1'b0, adr, 32'h0, x);
	endtask : rd

	// Command write, then poll busy under a bound
	task run_op(input op_t o, input logic [7:0] opnd, input logic [1:0] xs);
		logic [31:0] s;
		int          n;
		wr(ADR_CMD, {14'h0, xs, opnd, 3'h0, o});
		n = 0;
		do
		begin
			rd(ADR_STATUS, s);
			n++;
		end
		while (s[ST_BUSY_BIT] !== 1'b0 && n < 20);
		check({31'h0, s[ST_BUSY_BIT]}, 32'h0);
	endtask : run_op

	task acc_cc(input logic [23:0] acc, input logic [2:0] cc);
		rd(ADR_ACC, d);
		check(d, {8'h0, acc});
		rd(ADR_STATUS, d);
		check({29'h0, d[2:0]}, {29'h0, cc});
	endtask : acc_cc

	////////////////////////////////////////////////////////////////
	// Scenarios
	task t_reset;
		rd(ADR_ACC, d);
		check(d, 32'h0);
		rd(ADR_STATUS, d);
		check(d, 32'h0);
		wr(8'h30, 32'hFFFFFFFF);
		rd(8'h30, d);
		check(d, 32'h0);
		wr(ADR_ACC, 32'h00ABCDEF);
		wb_sel_i <= 4'h2;
		wr(ADR_ACC, 32'h00001200);
		wb_sel_i <= 4'hF;
		rd(ADR_ACC, d);
		check(d, 32'h00AB12EF);
		$display("reset and unmapped test done");
	endtask : t_reset

	task t_extend_negate;
		wr(ADR_ACC, 32'h00123480);
		run_op(sign_extend_low_byte, 8'h0, XSEL_NONE);
		acc_cc(24'hFFFF80, 3'h4);
		wr(ADR_ACC, 32'h00123400);
		run_op(zero_extend_low_byte, 8'h0, XSEL_NONE);
		acc_cc(24'h000000, 3'h4);
		wr(ADR_ACC, 32'h00ABCD05);
		run_op(negate_low_byte, 8'h0, XSEL_NONE);
		acc_cc(24'hABCDFB, 3'h4);
		wr(ADR_ACC, 32'h00000080);
		run_op(negate_low_byte, 8'h0, XSEL_NONE);
		rd(ADR_STATUS, d);
		check({31'h0, d[ST_OVF_BIT]}, 32'h1);
		wr(ADR_STATUS, 32'h8);
		rd(ADR_STATUS, d);
		check({31'h0, d[ST_OVF_BIT]}, 32'h0);
		$display("extend and negate test done");
	endtask : t_extend_negate

	// Operand ops: or, xor, sub, abs, query, compare, load
	task t_operand_ops;
		op_t        ops[8] = '{or_operand_into_byte, xor_operand_into_byte, subtract_operand_from_low_byte,
			absolute_low_byte, query_byte_bits, query_byte_bits, logical_compare_operand_byte,
			load_operand_to_low_byte};
		logic [7:0] av[8] = '{8'h41, 8'h5A, 8'h10, 8'hF6, 8'h40, 8'h0F, 8'h10, 8'h10};
		logic [7:0] bv[8] = '{8'h82, 8'h5A, 8'h30, 8'h00, 8'h40, 8'hF0, 8'h20, 8'h7F};
		logic [7:0] ev[8] = '{8'hC3, 8'h00, 8'hE0, 8'h0A, 8'h40, 8'h0F, 8'h10, 8'h7F};
		logic [2:0] cv[8] = '{3'h4, 3'h2, 3'h4, 3'h1, 3'h1, 3'h2, 3'h4, 3'h4};
		for (int i = 0; i < 8; i++)
		begin
			wr(ADR_ACC, {16'h00A5, 8'hC3, av[i]});
			run_op(ops[i], bv[i], XSEL_NONE);
			acc_cc({16'hA5C3, ev[i]}, cv[i]);
		end
		$display("operand test done");
	endtask : t_operand_ops

	task t_copy;
		logic [7:0] ra[5] = '{ADR_REG_I, ADR_REG_J, ADR_REG_K, ADR_REG_E, ADR_REG_T};
		logic [7:0] rs[5] = '{RSEL_I, RSEL_J, RSEL_K, RSEL_E, RSEL_T};
		wr(ADR_ACC, 32'h005A5A00);
		run_op(or_operand_into_byte, 8'h0, XSEL_NONE);
		for (int i = 0; i < 5; i++)
			wr(ra[i], {16'h0077, 8'(8'h13 + i)});
		for (int i = 0; i < 5; i++)
		begin
			run_op(copy_register_to_low_byte, rs[i], XSEL_NONE);
			acc_cc({16'h5A5A, 8'(8'h13 + i)}, 3'h2);
		end
		$display("copy test done");
	endtask : t_copy

	task t_memory;
		mem.words[8'h21] = 24'h123481;
		wr(ADR_EMA, 32'h21);
		wr(ADR_ACC, 32'h00FFFF00);
		run_op(load_memory_to_low_byte, 8'h0, XSEL_NONE);
		acc_cc(24'hFFFF81, 3'h4);
		slow <= 1'b1;
		mem.words[8'h22] = 24'hABCDEF;
		wr(ADR_EMA, 32'h22);
		wr(ADR_ACC, 32'h0000003C);
		run_op(store_low_byte_to_memory, 8'h0, XSEL_NONE);
		check({8'h0, mem.words[8'h22]}, 32'h00ABCD3C);
		slow <= 1'b0;
		$display("memory test done");
	endtask : t_memory

	task t_extract;
		logic [7:0] ev[4] = '{8'h66, 8'h44, 8'h55, 8'h66};
		mem.words[8'h30] = 24'h445566;
		mem.words[8'h35] = 24'h778899;
		wr(ADR_EMA, 32'h20);
		wr(ADR_REG_K, 32'h5);
		for (int s = 0; s < 4; s++)
		begin
			wr(ADR_REG_J, {8'h0, 2'(s), 22'h10});
			wr(ADR_ACC, 32'h0);
			run_op(extract_memory_byte, 8'h0, XSEL_NONE);
			rd(ADR_ACC, d);
			check(d, {24'h0, ev[s]});
		end
		wr(ADR_REG_J, {8'h0, SEL_HI, 22'h10});
		run_op(extract_memory_byte, 8'h0, XSEL_K);
		rd(ADR_ACC, d);
		check(d, 32'h77);
		$display("extract test done");
	endtask : t_extract

	task t_replace;
		logic [23:0] ev[4] = '{24'h112233, 24'hEE2233, 24'h11EE33, 24'h1122EE};
		wr(ADR_EMA, 32'h40);
		wr(ADR_ACC, 32'hEE);
		for (int s = 0; s < 4; s++)
		begin
			mem.words[8'h45] = 24'h112233;
			slow <= (s == 2);
			wr(ADR_REG_I, {8'h0, 2'(s), 22'h5});
			run_op(replace_memory_byte, 8'h0, XSEL_NONE);
			check({8'h0, mem.words[8'h45]}, {8'h0, ev[s]});
			rd(ADR_STATUS, d);
			check({31'h0, d[ST_NOP_BIT]}, {31'h0, s == 0});
		end
		slow <= 1'b0;
		mem.words[8'h47] = 24'h112233;
		wr(ADR_REG_J, 32'h2);
		wr(ADR_REG_I, {8'h0, SEL_LO, 22'h5});
		run_op(replace_memory_byte, 8'h0, XSEL_J);
		check({8'h0, mem.words[8'h47]}, 32'h001122EE);
		$display("replace test done");
	endtask : t_replace

	////////////////////////////////////////////////////////////////
	// Clock
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// Watchdog
	initial
	begin
		repeat (30000) @(posedge clk_i);
		fails++;
		complete_run;
	end

	// Main sequence
	initial
	begin
		rst_i    = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i  = 1'b0;
		wb_adr_i = 8'h0;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		slow     = 1'b0;
		fails    = 0;
		n_tests  = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_extend_negate;
		t_operand_ops;
		t_copy;
		t_memory;
		t_extract;
		t_replace;
		complete_run;
	end
endmodule : byte_processing_datapath_bench
